// *** core/sfps_pkg.sv ***
package sfps_pkg;

	// ------------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------------
	localparam logic [7:0] OPC_WRSR     = 8'h01;
	localparam logic [7:0] OPC_PP       = 8'h02;
	localparam logic [7:0] OPC_READ     = 8'h03;
	localparam logic [7:0] OPC_RDSR     = 8'h05;
	localparam logic [7:0] OPC_SE       = 8'h20;
	localparam logic [7:0] OPC_BE32     = 8'h52;
	localparam logic [7:0] OPC_BE64     = 8'hD8;
	localparam logic [7:0] OPC_BE128    = 8'hD2;
	localparam logic [7:0] OPC_CE_A     = 8'hC7;
	localparam logic [7:0] OPC_CE_B     = 8'h60;
	localparam logic [7:0] OPC_SUSPEND  = 8'h75;
	localparam logic [7:0] OPC_RESUME   = 8'h7A;

	// ------------------------------------------------------------------
	// Frame bit counts
	// ------------------------------------------------------------------
	localparam logic [5:0] BITS_OPC     = 6'h08;
	localparam logic [5:0] BITS_WRSR    = 6'h10;
	localparam logic [5:0] BITS_ADDR    = 6'h20;
	localparam logic [5:0] BITS_TOP     = 6'h3F;
	localparam logic [5:0] BITS_WRAP    = 6'h38;

	// ------------------------------------------------------------------
	// Region sizes as address LSB of the protected region
	// ------------------------------------------------------------------
	localparam logic [4:0] LSB_PAGE     = 5'h08;
	localparam logic [4:0] LSB_SECTOR   = 5'h0C;
	localparam logic [4:0] LSB_BLK32    = 5'h0F;
	localparam logic [4:0] LSB_BLK64    = 5'h10;
	localparam logic [4:0] LSB_BLK128   = 5'h11;

	// ------------------------------------------------------------------
	// Reset and delivery values
	// ------------------------------------------------------------------
	localparam logic [7:0]  STATUS_RESET = 8'h00;
	localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
	localparam logic [23:0] ADDR_RESET   = 24'h000000;
	localparam logic [31:0] CNT_ZERO     = 32'h00000000;

	// ------------------------------------------------------------------
	// Times and cycle counts (mclk 100 MHz)
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CYC_PER_US    = 1000 / CLK_PERIOD_NS;
	localparam int T_SUS_NS      = 2000;
	localparam int T_PUW_US      = 1000;
	localparam int T_PP_US       = 700;
	localparam int T_W_US        = 2000;
	localparam int T_SE_MS       = 100;
	localparam int T_BE_MS       = 400;
	localparam int T_CE_MS       = 8000;
	localparam logic [31:0] SUS_CYCLES = 32'(T_SUS_NS / CLK_PERIOD_NS);
	// Chip select sync and decode use part of the suspend budget
	localparam logic [31:0] SUS_SYNC_CYCLES = 32'h00000004;
	localparam logic [31:0] PUW_CYCLES = 32'(T_PUW_US * CYC_PER_US);
	localparam logic [31:0] PP_CYCLES  = 32'(T_PP_US * CYC_PER_US);
	localparam logic [31:0] W_CYCLES   = 32'(T_W_US * CYC_PER_US);
	localparam logic [31:0] SE_CYCLES  = 32'(T_SE_MS * 1000 * CYC_PER_US);
	localparam logic [31:0] BE_CYCLES  = 32'(T_BE_MS * 1000 * CYC_PER_US);
	localparam logic [31:0] CE_CYCLES  = 32'(T_CE_MS * 1000 * CYC_PER_US);

	typedef enum logic [1:0] {
		ST_IDLE       = 2'b00,
		ST_RUN        = 2'b01,
		ST_SUSPENDING = 2'b10,
		ST_SUSPENDED  = 2'b11
	} sfps_state_e;

endpackage

// *** core/sfps_link_if.sv ***
`timescale 1ns/100ps
interface sfps_link_if;
	logic [7:0]  opcode;
	logic [5:0]  bit_cnt;
	logic [23:0] addr;
	logic        busy;
	logic        sus_active;
	logic [23:0] sus_addr;
	logic [4:0]  sus_lsb;

	modport core (input opcode, bit_cnt, addr,
		output busy, sus_active, sus_addr, sus_lsb);
	modport link (output opcode, bit_cnt, addr,
		input busy, sus_active, sus_addr, sus_lsb);
endinterface

// *** core/sfps_sync.sv ***
`timescale 1ns/100ps
module sfps_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= d;
			q_reg    <= meta_reg;
		end
	end

	assign q = q_reg;
endmodule // sfps_sync

// *** core/sfps_link.sv ***
`timescale 1ns/100ps
module sfps_link
	import sfps_pkg::*;
(
	// Link pins
	input  wire logic sclk,
	input  wire logic rst_b,
	input  wire logic cs_b,
	input  wire logic si,
	output logic      so,
	output logic      so_oe,
	// Core side
	sfps_link_if.link lk
);
	logic        first_reg;
	logic [5:0]  cnt_reg,  cnt_next;
	logic [31:0] sh_reg,   sh_next;
	logic [7:0]  opc_reg,  opc_next;
	logic [23:0] addr_reg, addr_next;
	logic        so_reg,   so_next;
	logic        oe_reg,   oe_next;
	logic [1:0]  sync_q;
	logic        busy_s;
	logic        sus_s;
	logic        same_rgn;
	logic [7:0]  status;
	logic        out_clr;

	sfps_sync #(.W(2)) u_sync (
		.clk   (sclk),
		.rst_b (rst_b),
		.d     ({lk.busy, lk.sus_active}),
		.q     (sync_q)
	);
	assign busy_s  = sync_q[1];
	assign sus_s   = sync_q[0];
	assign out_clr = cs_b | ~rst_b;

	// ------------------------------------------------------------------
	// Frame start marker, set while deselected
	// ------------------------------------------------------------------
	always_ff @(posedge sclk or posedge cs_b) begin
		if (cs_b)
			first_reg <= 1'b1;
		else
			first_reg <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Input shifter; values stay frozen after chip select rises
	// ------------------------------------------------------------------
	always_comb begin
		sh_next   = {sh_reg[30:0], si};
		opc_next  = opc_reg;
		addr_next = addr_reg;
		if (first_reg)
			cnt_next = 6'h01;
		else if (cnt_reg == BITS_TOP)
			cnt_next = BITS_WRAP;
		else
			cnt_next = cnt_reg + 6'h01;
		if (cnt_next == BITS_OPC)
			opc_next = sh_next[7:0];
		if (cnt_next == BITS_ADDR)
			addr_next = sh_next[23:0];
	end

	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg  <= 6'h00;
			sh_reg   <= CNT_ZERO;
			opc_reg  <= 8'h00;
			addr_reg <= ADDR_RESET;
		end else begin
			cnt_reg  <= cnt_next;
			sh_reg   <= sh_next;
			opc_reg  <= opc_next;
			addr_reg <= addr_next;
		end
	end

	// ------------------------------------------------------------------
	// Output shifter on falling clock
	// ------------------------------------------------------------------
	// R13: status reads zero except busy
	assign status   = STATUS_RESET | {7'h00, busy_s};
	assign same_rgn = ((addr_reg ^ lk.sus_addr) >> lk.sus_lsb) == ADDR_RESET;

	always_comb begin
		so_next = 1'b0;
		oe_next = 1'b0;
		// R6: status served during suspend
		if (cnt_reg >= BITS_OPC && opc_reg == OPC_RDSR) begin
			oe_next = 1'b1;
			so_next = status[~cnt_reg[2:0]];
		end
		// R2: array read outside suspended region
		if (cnt_reg >= BITS_ADDR && opc_reg == OPC_READ) begin
			oe_next = !(sus_s && same_rgn);
			so_next = ERASED_BYTE[~cnt_reg[2:0]];
		end
	end

	always_ff @(negedge sclk or posedge out_clr) begin
		if (out_clr) begin
			so_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			so_reg <= so_next;
			oe_reg <= oe_next;
		end
	end

	assign so         = so_reg;
	assign so_oe      = oe_reg;
	assign lk.opcode  = opc_reg;
	assign lk.bit_cnt = cnt_reg;
	assign lk.addr    = addr_reg;
endmodule // sfps_link

// *** core/sfps_top.sv ***
`timescale 1ns/100ps
// Behaviour
// R1: suspend pauses running program or erase
// R2: reads outside suspended region still served
// R3: status write, program, erase blocked while suspended
// R4: suspend ignored unless program or erase runs; the code also ignores it during chip erase
// R5: suspend settles within suspend latency
// R6: status read served during suspend transition
// R7: busy high in transition, low when suspended
// R8: power loss clears suspended state
// R9: resume opcode continues suspended operation
// R10: busy set after resume until completion
// R11: resume ignored when nothing is suspended
// R12: writes refused during power-up write delay
// R13: erased array and zero status at start
// R14: suspend/resume only on clean byte boundary
module sfps_top
	import sfps_pkg::*;
#(
	parameter logic [31:0] PUW_CYC = PUW_CYCLES,
	parameter logic [31:0] PP_CYC  = PP_CYCLES,
	parameter logic [31:0] W_CYC   = W_CYCLES,
	parameter logic [31:0] SE_CYC  = SE_CYCLES,
	parameter logic [31:0] BE_CYC  = BE_CYCLES,
	parameter logic [31:0] CE_CYC  = CE_CYCLES
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_b,
	// Serial link
	input  wire logic sclk,
	input  wire logic cs_b,
	input  wire logic si,
	output logic      so,
	output logic      so_oe,
	// Status
	output logic      operation_busy_flag,
	output logic      op_suspended,
	output logic      write_inhibit
);
	sfps_link_if lk ();

	sfps_state_e state_reg,   state_next;
	logic [31:0] op_cnt_reg,  op_cnt_next;
	logic [31:0] sus_cnt_reg, sus_cnt_next;
	logic [31:0] puw_cnt_reg, puw_cnt_next;
	logic        sok_reg,     sok_next;
	logic [23:0] saddr_reg,   saddr_next;
	logic [4:0]  slsb_reg,    slsb_next;
	logic        busy_reg,    busy_next;
	logic        sus_reg,     sus_next;
	logic        inh_reg,     inh_next;
	logic        cs_d_reg;
	logic        arm_reg,     arm_next;
	logic        cs_s;
	logic        frame_end;
	logic        one_byte;
	logic        with_addr;
	logic        start;
	logic [31:0] st_cyc;
	logic [4:0]  st_lsb;
	logic        st_sok;

	sfps_link u_link (
		.sclk  (sclk),
		.rst_b (rst_b),
		.cs_b  (cs_b),
		.si    (si),
		.so    (so),
		.so_oe (so_oe),
		.lk    (lk.link)
	);

	sfps_sync #(.W(1)) u_cs_sync (
		.clk   (mclk),
		.rst_b (rst_b),
		.d     (cs_b),
		.q     (cs_s)
	);

	// ------------------------------------------------------------------
	// Frame end detection
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cs_d_reg <= 1'b1;
			arm_reg  <= 1'b0;
		end else begin
			cs_d_reg <= cs_s;
			arm_reg  <= arm_next;
		end
	end

	// Sync output starts low after reset; its first rise is no frame end
	assign arm_next  = arm_reg | cs_s;
	// Link fields are frozen once chip select is high
	assign frame_end = cs_s && !cs_d_reg && arm_reg;
	// R14: exactly eight bits then deselect
	assign one_byte  = lk.bit_cnt == BITS_OPC;
	assign with_addr = lk.bit_cnt >= BITS_ADDR;

	// ------------------------------------------------------------------
	// Start decode for program, erase and status write
	// ------------------------------------------------------------------
	always_comb begin
		start  = 1'b0;
		st_cyc = CNT_ZERO;
		st_lsb = LSB_PAGE;
		st_sok = 1'b0;
		case (lk.opcode)
			OPC_PP: begin
				start  = with_addr;
				st_cyc = PP_CYC;
				st_sok = 1'b1;
			end
			OPC_SE: begin
				start  = with_addr;
				st_cyc = SE_CYC;
				st_lsb = LSB_SECTOR;
				st_sok = 1'b1;
			end
			OPC_BE32: begin
				start  = with_addr;
				st_cyc = BE_CYC;
				st_lsb = LSB_BLK32;
				st_sok = 1'b1;
			end
			OPC_BE64: begin
				start  = with_addr;
				st_cyc = BE_CYC;
				st_lsb = LSB_BLK64;
				st_sok = 1'b1;
			end
			OPC_BE128: begin
				start  = with_addr;
				st_cyc = BE_CYC;
				st_lsb = LSB_BLK128;
				st_sok = 1'b1;
			end
			OPC_CE_A, OPC_CE_B: begin
				start  = one_byte;
				st_cyc = CE_CYC;
			end
			OPC_WRSR: begin
				start  = lk.bit_cnt >= BITS_WRSR;
				st_cyc = W_CYC;
			end
			default: begin
				start = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Operation sequencer
	// ------------------------------------------------------------------
	always_comb begin
		state_next   = state_reg;
		op_cnt_next  = op_cnt_reg;
		sus_cnt_next = sus_cnt_reg;
		sok_next     = sok_reg;
		saddr_next   = saddr_reg;
		slsb_next    = slsb_reg;
		// R12: power-up write delay countdown
		puw_cnt_next = (puw_cnt_reg != CNT_ZERO) ?
			puw_cnt_reg - 32'h00000001 : CNT_ZERO;
		case (state_reg)
			ST_IDLE: begin
				// R12: writes refused while inhibited
				if (frame_end && start && puw_cnt_reg == CNT_ZERO) begin
					state_next  = ST_RUN;
					op_cnt_next = st_cyc;
					sok_next    = st_sok;
					saddr_next  = lk.addr;
					slsb_next   = st_lsb;
				end
			end
			ST_RUN: begin
				op_cnt_next = op_cnt_reg - 32'h00000001;
				if (op_cnt_reg <= 32'h00000001) begin
					state_next  = ST_IDLE;
					op_cnt_next = CNT_ZERO;
				// R4: only program or erase suspends
				end else if (frame_end && one_byte && sok_reg &&
						lk.opcode == OPC_SUSPEND) begin
					// R1: pause the running operation
					state_next   = ST_SUSPENDING;
					op_cnt_next  = op_cnt_reg;
					// R5: bounded suspend latency
					sus_cnt_next = SUS_CYCLES - SUS_SYNC_CYCLES;
				end
			end
			ST_SUSPENDING: begin
				sus_cnt_next = sus_cnt_reg - 32'h00000001;
				if (sus_cnt_reg == CNT_ZERO) begin
					state_next   = ST_SUSPENDED;
					sus_cnt_next = CNT_ZERO;
				end
			end
			ST_SUSPENDED: begin
				// R3: other writes simply fall through
				// R9: resume continues remaining count
				// R11: resume only when suspended
				if (frame_end && one_byte && lk.opcode == OPC_RESUME)
					state_next = ST_RUN;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// R7: busy in transition and run only
		// R10: busy again after resume
		busy_next = state_next == ST_RUN || state_next == ST_SUSPENDING;
		sus_next  = state_next == ST_SUSPENDING ||
			state_next == ST_SUSPENDED;
		inh_next  = puw_cnt_next != CNT_ZERO;
	end

	// R8: reset clears suspension
	// R13: status zero after reset
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg   <= ST_IDLE;
			op_cnt_reg  <= CNT_ZERO;
			sus_cnt_reg <= CNT_ZERO;
			puw_cnt_reg <= PUW_CYC;
			sok_reg     <= 1'b0;
			saddr_reg   <= ADDR_RESET;
			slsb_reg    <= LSB_PAGE;
			busy_reg    <= 1'b0;
			sus_reg     <= 1'b0;
			inh_reg     <= 1'b1;
		end else begin
			state_reg   <= state_next;
			op_cnt_reg  <= op_cnt_next;
			sus_cnt_reg <= sus_cnt_next;
			puw_cnt_reg <= puw_cnt_next;
			sok_reg     <= sok_next;
			saddr_reg   <= saddr_next;
			slsb_reg    <= slsb_next;
			busy_reg    <= busy_next;
			sus_reg     <= sus_next;
			inh_reg     <= inh_next;
		end
	end

	assign lk.busy             = busy_reg;
	assign lk.sus_active       = sus_reg;
	assign lk.sus_addr         = saddr_reg;
	assign lk.sus_lsb          = slsb_reg;
	assign operation_busy_flag = busy_reg;
	assign op_suspended        = sus_reg;
	assign write_inhibit       = inh_reg;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	localparam int A_SUS = int'(SUS_CYCLES - SUS_SYNC_CYCLES) + 1;

	default clocking a_clk @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_suspend_enter: assert property ( // R1
		state_reg == ST_RUN && op_cnt_reg > 32'h00000001 && frame_end
		&& one_byte && sok_reg && lk.opcode == OPC_SUSPEND
		|=> state_reg == ST_SUSPENDING && $stable(op_cnt_reg))
		else $error("suspend not entered");
	a_suspend_idle: assert property ( // R4
		state_reg == ST_IDLE && frame_end && lk.opcode == OPC_SUSPEND
		|=> state_reg == ST_IDLE && !busy_reg)
		else $error("suspend acted while idle");
	a_suspend_time: assert property ( // R5
		$rose(sus_reg) |-> ##[1:A_SUS] state_reg == ST_SUSPENDED)
		else $error("suspend latency exceeded");
	a_busy_trans: assert property ( // R7
		state_reg == ST_SUSPENDING |-> busy_reg && sus_reg)
		else $error("busy low during suspend transition");
	a_busy_done: assert property ( // R7
		state_reg == ST_SUSPENDED |-> !busy_reg && sus_reg)
		else $error("busy high while suspended");
	a_forbid_cmd: assert property ( // R3
		state_reg == ST_SUSPENDED && frame_end && start
		|=> state_reg == ST_SUSPENDED && $stable(op_cnt_reg))
		else $error("write command ran while suspended");
	a_resume_run: assert property ( // R10
		state_reg == ST_SUSPENDED && frame_end && one_byte
		&& lk.opcode == OPC_RESUME
		|=> busy_reg && state_reg == ST_RUN ##1 busy_reg)
		else $error("resume did not set busy");
	a_resume_ignore: assert property ( // R11
		state_reg == ST_IDLE && frame_end && lk.opcode == OPC_RESUME
		|=> state_reg == ST_IDLE && $stable(op_cnt_reg))
		else $error("resume acted without suspend");
	a_powerup_inh: assert property ( // R12
		inh_reg && state_reg == ST_IDLE |=> state_reg == ST_IDLE)
		else $error("write accepted during power-up delay");
	a_byte_edge: assert property ( // R14
		frame_end && !one_byte && state_reg == ST_RUN
		|=> state_reg != ST_SUSPENDING)
		else $error("suspend taken off byte boundary");

	c_suspend: cover property (state_reg == ST_SUSPENDED);
	c_resume: cover property (
		state_reg == ST_SUSPENDED ##1 state_reg == ST_RUN);
	c_forbid: cover property (state_reg == ST_SUSPENDED && frame_end
		&& start);
	c_finish: cover property (state_reg == ST_RUN ##1
		state_reg == ST_IDLE);
endmodule // sfps_top

// *** tb/sfps_host.sv ***
`timescale 1ns/100ps
module sfps_host (
	// Link pins to the device
	output logic      sclk,
	output logic      cs_b,
	output logic      si,
	// Link pins from the device
	input  wire logic so,
	input  wire logic so_oe
);

	realtime t_end;

	initial begin
		sclk  = 1'b0;
		cs_b  = 1'b1;
		si    = 1'b0;
		t_end = 0.0;
	end

	// ------------------------------------------------------------------
	// Framed command, link clock 48 ns, runs only inside the frame
	// ------------------------------------------------------------------
	task automatic frame(input logic [7:0] opc, input logic [23:0] addr,
		input int nbits, output logic [7:0] rx, output logic oe);
		logic [31:0] sh;
		sh   = {opc, addr};
		rx   = 8'h00;
		oe   = 1'b0;
		cs_b = 1'b0;
		#10;
		for (int i = 0; i < nbits; i++) begin
			si = sh[31];
			sh = {sh[30:0], 1'b0};
			#24 sclk = 1'b1;
			if (i >= 8) begin
				rx = {rx[6:0], so};
				oe = so_oe;
			end
			#24 sclk = 1'b0;
		end
		#10;
		cs_b  = 1'b1;
		t_end = $realtime;
		si    = ~si;
		#100;
	endtask

endmodule // sfps_host

// *** tb/sfps_top_tb_top.sv ***
`timescale 1ns/100ps
module sfps_top_tb_top;
	import sfps_pkg::*;

	localparam logic [31:0] PUW = 32'h00000190;
	localparam int          SUS = 200;

	logic       mclk;
	logic       rst_b;
	logic       sclk;
	logic       cs_b;
	logic       si;
	logic       so;
	logic       so_oe;
	logic       busy;
	logic       susp;
	logic       winh;
	logic [7:0] rx;
	logic       oe;
	int         n;
	int         n_mismatch;
	int         tests_run;
	realtime    t_rel;

	sfps_top #(.PUW_CYC(PUW), .PP_CYC(32'h0000012C), .W_CYC(32'h0000012C),
		.SE_CYC(32'h00000190), .BE_CYC(32'h000001F4),
		.CE_CYC(32'h00000258)) i_sfps_top (.mclk(mclk), .rst_b(rst_b),
		.sclk(sclk), .cs_b(cs_b), .si(si), .so(so), .so_oe(so_oe),
		.operation_busy_flag(busy), .op_suspended(susp),
		.write_inhibit(winh));

	sfps_host i_sfps_host (.sclk(sclk), .cs_b(cs_b), .si(si), .so(so),
		.so_oe(so_oe));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic h(input logic [7:0] op, input logic [23:0] a,
		input int nb);
		i_sfps_host.frame(op, a, nb, rx, oe);
	endtask

	task automatic wait_busy(input logic v, input int lim);
		n = 0;
		while (busy !== v && n < lim) begin
			@(negedge mclk);
			n++;
		end
	endtask

	task automatic wait_winh();
		n = 0;
		// host waits out the write delay
		while (winh !== 1'b0 && n < 1000) begin
			@(negedge mclk);
			n++;
		end
	endtask

	task automatic do_reset();
		@(negedge mclk);
		rst_b = 1'b0;
		repeat (16) @(negedge mclk);
		chk(32'({busy, susp, winh}), 32'h1);
		rst_b = 1'b1;
		t_rel = $realtime;
	endtask

	task automatic finish_test();
		$display("Mismatches %0d of %0d comparisons", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_powerup();
		int e;
		do_reset();
		h(OPC_PP, 24'h000100, 32);
		chk(32'(busy), 32'h0);
		wait_winh();
		e = int'(($realtime - t_rel) / 10.0);
		chk(32'(e >= int'(PUW) && e <= int'(PUW) + 3), 32'h1);
		h(OPC_RDSR, 24'h000000, 16);
		chk(32'(rx), 32'(STATUS_RESET));
		h(OPC_READ, 24'h0ABCDE, 40);
		chk(32'({oe, rx}), 32'({1'b1, ERASED_BYTE}));
	endtask

	task automatic t_ignore();
		h(OPC_SUSPEND, 24'h000000, 8);
		chk(32'({busy, susp}), 32'h0);
		h(OPC_RESUME, 24'h000000, 8);
		chk(32'({busy, susp}), 32'h0);
		h(OPC_PP, 24'h000300, 32);
		h(OPC_SUSPEND, 24'h000000, 9);
		chk(32'({busy, susp}), 32'h2);
		h(OPC_RESUME, 24'h000000, 8);
		chk(32'({busy, susp}), 32'h2);
		wait_busy(1'b0, 600);
		h(OPC_CE_A, 24'h000000, 8);
		h(OPC_SUSPEND, 24'h000000, 8);
		chk(32'({busy, susp}), 32'h2);
		wait_busy(1'b0, 800);
		chk(32'(busy), 32'h0);
	endtask

	task automatic t_suspend(input logic [7:0] op, input logic [23:0] a);
		logic [7:0] fb[8];
		int         fbn[8];
		realtime    t0;
		int         e;
		fb  = '{OPC_WRSR, OPC_PP, OPC_SE, OPC_BE32, OPC_BE64, OPC_BE128,
			OPC_CE_A, OPC_CE_B};
		fbn = '{16, 32, 32, 32, 32, 32, 8, 8};
		h(op, a, 32);
		chk(32'(busy), 32'h1);
		h(OPC_SUSPEND, 24'h000000, 8);
		t0 = i_sfps_host.t_end;
		chk(32'(susp), 32'h1);
		h(OPC_RDSR, 24'h000000, 16);
		chk(32'(rx), 32'h01);
		wait_busy(1'b0, 300);
		e = int'($realtime - t0);
		chk(32'(e >= (SUS - 1) * 10 && e <= SUS * 10 + 5), 32'h1);
		h(OPC_RDSR, 24'h000000, 16);
		chk(32'(rx), 32'h00);
		h(OPC_READ, a ^ 24'h080000, 40);
		chk(32'({oe, rx}), 32'({1'b1, ERASED_BYTE}));
		h(OPC_READ, a, 40);
		chk(32'(oe), 32'h0);
		for (int i = 0; i < 8; i++) begin
			h(fb[i], a, fbn[i]);
			chk(32'({busy, susp}), 32'h1);
		end
		h(OPC_RESUME, 24'h000000, 8);
		chk(32'({busy, susp}), 32'h2);
		wait_busy(1'b0, 600);
		chk(32'(n > 0 && n < 600), 32'h1);
	endtask

	task automatic t_powerloss();
		h(OPC_BE64, 24'h020000, 32);
		h(OPC_SUSPEND, 24'h000000, 8);
		wait_busy(1'b0, 300);
		chk(32'(susp), 32'h1);
		do_reset();
		wait_winh();
		h(OPC_RESUME, 24'h000000, 8);
		chk(32'({busy, susp}), 32'h0);
	endtask

	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		logic [7:0]  ops[5];
		logic [23:0] adr[5];
		rst_b      = 1'b1;
		n_mismatch = 0;
		tests_run  = 0;
		ops = '{OPC_SE, OPC_BE32, OPC_BE64, OPC_BE128, OPC_PP};
		adr = '{24'h001000, 24'h010000, 24'h030000, 24'h040000, 24'h000200};
		t_powerup();
		t_ignore();
		for (int i = 0; i < 5; i++) begin
			t_suspend(ops[i], adr[i]);
		end
		t_powerloss();
		finish_test();
	end

	initial begin
		#400000;
		n_mismatch++;
		finish_test();
	end

endmodule // sfps_top_tb_top
